// ==== dqm_pkg.sv ====
// Shared constants and helpers for the descriptor queue manager
package dqm_pkg;
    localparam int DQM_REGIONS = 16;
    localparam int DQM_QUEUES = 4;
    localparam int DQM_QDEPTH = 16;
    localparam int DQM_QPTR_W = 4;
    // Address decode, byte address bits [11:0]
    localparam logic [3:0] DQM_BLK_REGION = 4'h0;
    localparam logic [3:0] DQM_BLK_QUEUE = 4'h1;
    localparam logic [11:0] DQM_ADDR_LINK = 12'h200;
    localparam logic [1:0] DQM_OFF_BASE_LO = 2'h0;
    localparam logic [1:0] DQM_OFF_BASE_HI = 2'h1;
    localparam logic [1:0] DQM_OFF_GEOM = 2'h2;
    localparam logic [1:0] DQM_OFF_LINK = 2'h3;
    localparam logic [2:0] DQM_OFF_PP_LO = 3'h0;
    localparam logic [2:0] DQM_OFF_PP_HI = 3'h1;
    localparam logic [2:0] DQM_OFF_TALLY = 3'h2;
    localparam logic [2:0] DQM_OFF_BYTES_LO = 3'h3;
    localparam logic [2:0] DQM_OFF_BYTES_HI = 3'h4;
    localparam logic [2:0] DQM_OFF_HEAD = 3'h5;
    // Field positions
    localparam int DQM_GEOM_DSZ_LSB = 8;
    localparam int DQM_GEOM_RSZ_LSB = 0;
    localparam int DQM_LINK_W = 14;
    localparam int DQM_HINT_W = 5;
    localparam int DQM_PTR_LSB = 5;
    localparam int DQM_TALLY_W = 14;
    localparam int DQM_BYTES_W = 28;
    localparam int DQM_BYTES_HI_W = 12;
    localparam logic [15:0] DQM_RESET_WORD = 16'h0000;
    localparam logic [3:0] DQM_DSZ_MAX = 4'h8;
    localparam logic [7:0] DQM_HINT_BASE = 8'h18;

    typedef enum logic [1:0] {
        DQM_BUS_IDLE = 2'b01,
        DQM_BUS_DONE = 2'b10
    } dqm_bus_t;

    // Bytes described by a push size hint: 24 + 4 * code
    function automatic logic [13:0] dqm_hint_bytes(input logic [4:0] code);
        return 14'(DQM_HINT_BASE) + {7'h00, code, 2'b00};
    endfunction

    // Log2 of region descriptor size; 0 for reserved codes
    function automatic logic [4:0] dqm_dsz_log2(input logic [3:0] code);
        return (code > DQM_DSZ_MAX) ? 5'h00 : 5'(code) + 5'h05;
    endfunction
endpackage

// ==== dqm_queue_store.sv ====
// One descriptor queue with entry and byte tallies
`timescale 1ns/1ps
module dqm_queue_store
    import dqm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [31:0] push_data,
    input wire logic pop,
    output logic [31:0] head_data,
    output logic empty,
    output logic full,
    output logic [DQM_TALLY_W-1:0] tally,
    output logic [DQM_BYTES_W-1:0] bytes
);
    logic [31:0] mem [DQM_QDEPTH];
    logic [DQM_QPTR_W-1:0] wr_ff;
    logic [DQM_QPTR_W-1:0] rd_ff;
    logic [DQM_TALLY_W-1:0] tally_ff;
    logic [DQM_BYTES_W-1:0] bytes_ff;
    logic do_push;
    logic do_pop;
    logic [DQM_BYTES_W-1:0] add_b;
    logic [DQM_BYTES_W-1:0] sub_b;

    assign empty = (tally_ff == '0);
    assign full = (tally_ff == DQM_TALLY_W'(DQM_QDEPTH));
    assign do_pop = pop && !empty;
    assign do_push = push && (!full || do_pop);
    assign head_data = empty ? 32'h0000_0000 : mem[rd_ff];
    assign add_b = do_push ? 28'(dqm_hint_bytes(push_data[4:0])) : '0;
    assign sub_b = do_pop ? 28'(dqm_hint_bytes(mem[rd_ff][4:0])) : '0;
    assign tally = tally_ff;
    assign bytes = bytes_ff;

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ff] <= push_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (do_push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
        end
    end

    // Tallies move with the same commit as the contents
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tally_ff <= '0;
            bytes_ff <= '0;
        end else begin
            tally_ff <= tally_ff + DQM_TALLY_W'(do_push) - DQM_TALLY_W'(do_pop);
            bytes_ff <= bytes_ff + add_b - sub_b;
        end
    end
endmodule // dqm_queue_store

// ==== dqm_descriptor_queue_manager.sv ====
// Descriptor queue manager: APB registers, regions, queues, link address
// Notes on behaviour
// - Sixteen regions, each with 32-bit base.
// - Descriptor size code 0-8: 32 to 8K.
// - Region size code: 32 doubling to 4K.
// - Second control word holds linking start index.
// - Write pushes descriptor; read pops head.
// - Only the high word commits push/pop.
// - Pointer from word bits; zero means empty.
// - Size hint: 24 bytes plus 4 per step.
// - Empty pop returns zero hint and pointer.
// - Entry tally readable, 14 bits.
// - 28-bit byte total split over two words.
// - Head packet size readable in bits 13-0.
// - Link address = base plus index shifted two.
`timescale 1ns/1ps
module dqm_descriptor_queue_manager
    import dqm_pkg::*;
#(
    parameter logic [31:0] LINK_RAM_BASE = 32'h0000_0000
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] link_addr,
    output logic link_valid
);
    dqm_bus_t bus_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] link_addr_ff;
    logic link_valid_ff;

    logic [15:0] base_lo_ff [DQM_REGIONS];
    logic [15:0] base_hi_ff [DQM_REGIONS];
    logic [3:0] dsz_ff [DQM_REGIONS];
    logic [2:0] rsz_ff [DQM_REGIONS];
    logic [DQM_LINK_W-1:0] start_ff [DQM_REGIONS];
    logic [15:0] stage_ff [DQM_QUEUES];

    logic access;
    logic is_region;
    logic is_queue;
    logic is_link;
    logic [3:0] rsel;
    logic [1:0] roff;
    logic [1:0] qsel;
    logic [2:0] qoff;
    logic q_ok;
    logic mapped;

    logic [DQM_QUEUES-1:0] q_push;
    logic [DQM_QUEUES-1:0] q_pop;
    logic [31:0] q_head [DQM_QUEUES];
    logic [DQM_TALLY_W-1:0] q_tally [DQM_QUEUES];
    logic [DQM_BYTES_W-1:0] q_bytes [DQM_QUEUES];
    logic [DQM_QUEUES-1:0] q_empty;

    logic [31:0] push_word;
    logic [31:0] push_ptr;
    logic [31:0] nxt_prdata;
    logic nxt_link_hit;
    logic [31:0] nxt_link_addr;

    // Request decode
    assign access = psel && penable && (bus_ff == DQM_BUS_IDLE);
    assign is_region = (paddr[11:8] == DQM_BLK_REGION);
    assign is_queue = (paddr[11:8] == DQM_BLK_QUEUE);
    assign is_link = (paddr == DQM_ADDR_LINK);
    assign rsel = paddr[7:4];
    assign roff = paddr[3:2];
    assign qsel = paddr[6:5];
    assign qoff = paddr[4:2];
    assign q_ok = !paddr[7] && (qoff <= DQM_OFF_HEAD);
    assign mapped = (paddr[1:0] == 2'b00) && (is_region || (is_queue && q_ok) || is_link);

    // Pushed word: staged low word with the high word being written
    assign push_word = {pwdata[15:0], stage_ff[qsel]};
    assign push_ptr = {push_word[31:DQM_PTR_LSB], 5'h00};

    always_comb begin
        for (int n = 0; n < DQM_QUEUES; n++) begin
            q_push[n] = access && mapped && is_queue && pwrite
                && (qsel == 2'(n)) && (qoff == DQM_OFF_PP_HI)
                && (push_ptr != 32'h0000_0000);
            q_pop[n] = access && mapped && is_queue && !pwrite
                && (qsel == 2'(n)) && (qoff == DQM_OFF_PP_HI);
        end
    end

    for (genvar g = 0; g < DQM_QUEUES; g++) begin : g_queue
        dqm_queue_store u_store (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .push(q_push[g]),
            .push_data(push_word),
            .pop(q_pop[g]),
            .head_data(q_head[g]),
            .empty(q_empty[g]),
            .full(),
            .tally(q_tally[g]),
            .bytes(q_bytes[g])
        );
    end

    // Read mux; reserved bits come back as zero
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (is_link) begin
            nxt_prdata = {link_addr_ff[31:1], link_valid_ff};
        end else if (is_region) begin
            case (roff)
                DQM_OFF_BASE_LO: nxt_prdata[15:0] = base_lo_ff[rsel];
                DQM_OFF_BASE_HI: nxt_prdata[15:0] = base_hi_ff[rsel];
                DQM_OFF_GEOM: begin
                    nxt_prdata[DQM_GEOM_DSZ_LSB +: 4] = dsz_ff[rsel];
                    nxt_prdata[DQM_GEOM_RSZ_LSB +: 3] = rsz_ff[rsel];
                end
                DQM_OFF_LINK: nxt_prdata[DQM_LINK_W-1:0] = start_ff[rsel];
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end else if (is_queue && q_ok) begin
            case (qoff)
                DQM_OFF_PP_LO: nxt_prdata[15:0] = q_head[qsel][15:0];
                DQM_OFF_PP_HI: nxt_prdata[15:0] = q_head[qsel][31:16];
                DQM_OFF_TALLY: nxt_prdata[DQM_TALLY_W-1:0] = q_tally[qsel];
                DQM_OFF_BYTES_LO: nxt_prdata[15:0] = q_bytes[qsel][15:0];
                DQM_OFF_BYTES_HI:
                    nxt_prdata[DQM_BYTES_HI_W-1:0] = q_bytes[qsel][DQM_BYTES_W-1:16];
                DQM_OFF_HEAD: begin
                    if (!q_empty[qsel]) begin
                        nxt_prdata[13:0] = dqm_hint_bytes(q_head[qsel][4:0]);
                    end
                end
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus handshake: one wait state, answer from flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_ff <= DQM_BUS_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            case (bus_ff)
                DQM_BUS_IDLE: begin
                    if (access) begin
                        bus_ff <= DQM_BUS_DONE;
                        pready_ff <= 1'b1;
                        pslverr_ff <= !mapped;
                        prdata_ff <= (mapped && !pwrite) ? nxt_prdata : 32'h0000_0000;
                    end
                end
                DQM_BUS_DONE: begin
                    bus_ff <= DQM_BUS_IDLE;
                    pready_ff <= 1'b0;
                    pslverr_ff <= 1'b0;
                end
                default: begin
                    bus_ff <= DQM_BUS_IDLE;
                    pready_ff <= 1'b0;
                    pslverr_ff <= 1'b0;
                end
            endcase
        end
    end

    // Region configuration writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int r = 0; r < DQM_REGIONS; r++) begin
                base_lo_ff[r] <= DQM_RESET_WORD;
                base_hi_ff[r] <= DQM_RESET_WORD;
                dsz_ff[r] <= 4'h0;
                rsz_ff[r] <= 3'h0;
                start_ff[r] <= '0;
            end
        end else if (access && mapped && pwrite && is_region) begin
            case (roff)
                DQM_OFF_BASE_LO: base_lo_ff[rsel] <= pwdata[15:0];
                DQM_OFF_BASE_HI: base_hi_ff[rsel] <= pwdata[15:0];
                DQM_OFF_GEOM: begin
                    dsz_ff[rsel] <= pwdata[DQM_GEOM_DSZ_LSB +: 4];
                    rsz_ff[rsel] <= pwdata[DQM_GEOM_RSZ_LSB +: 3];
                end
                DQM_OFF_LINK: start_ff[rsel] <= pwdata[DQM_LINK_W-1:0];
                default: ;
            endcase
        end
    end

    // Low push word is held until the high word commits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int n = 0; n < DQM_QUEUES; n++) begin
                stage_ff[n] <= DQM_RESET_WORD;
            end
        end else if (access && mapped && pwrite && is_queue && (qoff == DQM_OFF_PP_LO)) begin
            stage_ff[qsel] <= pwdata[15:0];
        end
    end

    // Region lookup for the pushed pointer; lowest matching region wins
    always_comb begin
        logic [31:0] base;
        logic [31:0] delta;
        logic [4:0] dlog;
        logic [5:0] span_log;
        logic [31:0] idx;
        base = 32'h0000_0000;
        delta = 32'h0000_0000;
        dlog = 5'h00;
        span_log = 6'h00;
        idx = 32'h0000_0000;
        nxt_link_hit = 1'b0;
        nxt_link_addr = 32'h0000_0000;
        for (int r = DQM_REGIONS - 1; r >= 0; r--) begin
            base = {base_hi_ff[r], base_lo_ff[r]};
            delta = push_ptr - base;
            dlog = dqm_dsz_log2(dsz_ff[r]);
            span_log = 6'(dlog) + 6'(rsz_ff[r]) + 6'h05;
            if ((dlog != 5'h00) && (push_ptr >= base) && ((delta >> span_log) == 32'h0)) begin
                idx = 32'(start_ff[r]) + (delta >> dlog);
                nxt_link_hit = 1'b1;
                nxt_link_addr = LINK_RAM_BASE + (idx << 2);
            end
        end
    end

    // Link address of the last pushed descriptor
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            link_addr_ff <= 32'h0000_0000;
            link_valid_ff <= 1'b0;
        end else if (|q_push) begin
            link_addr_ff <= nxt_link_addr;
            link_valid_ff <= nxt_link_hit;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign link_addr = link_addr_ff;
    assign link_valid = link_valid_ff;
endmodule // dqm_descriptor_queue_manager

// ==== dqm_checker.sv ====
// Port assertions for the descriptor queue manager
`timescale 1ns/1ps
module dqm_checker
    import dqm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] link_addr,
    input wire logic link_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic take;
    assign take = psel && penable && !pready;
    ready_after_take_a: assert property (take |=> pready)
        else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(take))
        else $error("ready without an access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag outside answer");
    misalign_err_a: assert property (take && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    upper_zero_a: assert property (pready && !pwrite && paddr != DQM_ADDR_LINK
        |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    link_read_a: assert property (pready && !pwrite && paddr == DQM_ADDR_LINK
        |-> prdata == {link_addr[31:1], link_valid})
        else $error("link word differs from link outputs");
    link_hold_a: assert property (!(take && pwrite)
        |=> $stable(link_addr) && $stable(link_valid))
        else $error("link output moved without a write");
    reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> !pready && !pslverr
        && prdata == 32'h0 && !link_valid && link_addr == 32'h0)
        else $error("outputs not cleared by reset");
    cover property (pslverr);
    cover property (pready && pwrite);
    cover property ($rose(link_valid));
endmodule // dqm_checker
bind dqm_descriptor_queue_manager dqm_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_addr(link_addr),
    .link_valid(link_valid));

// ==== dqm_host_model.sv ====
// APB host model for the queue manager register port
`timescale 1ns/1ps
module dqm_host_model (
    input wire logic sys_clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // Whole 16-bit word per access, held until ready or 16 wait cycles
    task automatic xfer(input logic wr, input logic [11:0] adr, input logic [15:0] dat,
                        output logic [31:0] rdat, output logic err, output logic hung);
        int waits;
        waits = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= {16'h0000, dat};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            waits++;
        end while (!pready && waits < 16);
        rdat = prdata;
        err = pslverr;
        hung = !pready;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~pwdata;
    endtask
endmodule // dqm_host_model

// ==== test_descriptor_queue_manager.sv ====
// Self-checking bench for the descriptor queue manager
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_descriptor_queue_manager;
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, link_valid, err, hung;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, link_addr, rd;
    int miscompares, checks;
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    dqm_descriptor_queue_manager #(.LINK_RAM_BASE(32'h0000_1000)) dut_u (.sys_clk(sys_clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_addr(link_addr), .link_valid(link_valid));
    dqm_host_model host_u (.sys_clk(sys_clk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
        host_u.xfer(w, a, d, rd, err, hung);
        `CHK(hung, 1'b0)
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 16'h0000);
        `CHK(rd, exp)
    endtask
    task automatic push(input logic [15:0] lo, input logic [15:0] hi);
        acc(1'b1, 12'h100, lo);
        acc(1'b1, 12'h104, hi);
    endtask
    task automatic t_reset_values;
        rchk(12'h008, 32'h0);
        rchk(12'h128, 32'h0);
        rchk(12'h10C, 32'h0);
        rchk(12'h114, 32'h0);
        rchk(12'h200, 32'h0);
    endtask
    task automatic t_region_regs;
        acc(1'b1, 12'h010, 16'hFFFF);
        acc(1'b1, 12'h014, 16'hA5A5);
        acc(1'b1, 12'h018, 16'hFFFF);
        acc(1'b1, 12'h01C, 16'hFFFF);
        acc(1'b1, 12'h0F4, 16'h1234);
        rchk(12'h010, 32'hFFFF);
        rchk(12'h014, 32'hA5A5);
        rchk(12'h018, 32'h0F07);
        rchk(12'h01C, 32'h3FFF);
        rchk(12'h0F4, 32'h1234);
    endtask
    task automatic t_queue_flow;
        // Region 0: base 0x10000, 64-byte descriptors, 32 of them, index 0x10
        acc(1'b1, 12'h004, 16'h0001);
        acc(1'b1, 12'h008, 16'h0100);
        acc(1'b1, 12'h00C, 16'h0010);
        acc(1'b1, 12'h100, 16'h0083);
        rchk(12'h108, 32'h0);
        acc(1'b1, 12'h104, 16'h0001);
        rchk(12'h108, 32'h1);
        rchk(12'h200, 32'h1049);
        `CHK(link_valid, 1'b1)
        `CHK(link_addr, 32'h0000_1048)
        rchk(12'h114, 32'h24);
        push(16'h07FF, 16'h0001);
        rchk(12'h200, 32'h10BD);
        push(16'h0800, 16'h0001);
        rchk(12'h200, 32'h0);
        `CHK(link_valid, 1'b0)
        push(16'h0000, 16'h0000);
        rchk(12'h108, 32'h3);
        rchk(12'h10C, 32'hD0);
        rchk(12'h110, 32'h0);
        rchk(12'h100, 32'h0083);
        rchk(12'h108, 32'h3);
        rchk(12'h104, 32'h0001);
        rchk(12'h108, 32'h2);
        rchk(12'h10C, 32'hAC);
        rchk(12'h114, 32'h94);
        rchk(12'h100, 32'h07FF);
        rchk(12'h104, 32'h0001);
        rchk(12'h100, 32'h0800);
        rchk(12'h104, 32'h0001);
        rchk(12'h100, 32'h0);
        rchk(12'h104, 32'h0);
        rchk(12'h10C, 32'h0);
    endtask
    task automatic t_refused;
        acc(1'b0, 12'h300, 16'h0000);
        `CHK(err, 1'b1)
        acc(1'b0, 12'h002, 16'h0000);
        `CHK(err, 1'b1)
        acc(1'b1, 12'h108, 16'hFFFF);
        rchk(12'h108, 32'h0);
    endtask
    task automatic wrap_up;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_values;
        t_region_regs;
        t_queue_flow;
        t_refused;
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        wrap_up;
    end
endmodule // test_descriptor_queue_manager
